// ---- afecr_pkg.sv ----
// Package for the front-end control and test register bank
package afecr_pkg;

  // Register addresses
  localparam logic [7:0] FE_CTRL_ADDR = 8'h00;
  localparam logic [7:0] TEST_LB_ADDR = 8'h01;

  // Reset values
  localparam logic [7:0] FE_CTRL_RST = 8'h08;
  localparam logic [7:0] TEST_LB_RST = 8'h00;

  // Front-end control field positions
  localparam int FE_EN_BIT = 7;
  localparam int DRV2_SEL_BIT = 6;
  localparam int TX_BOOST1_BIT = 5;
  localparam int TX_BOOST0_BIT = 4;
  localparam int TX_DIS_BIT = 3;
  localparam int RX_GAIN_HI_BIT = 2;
  localparam int RX_GAIN_LO_BIT = 1;
  localparam int RX_BOOST_BIT = 0;

  // Test register field positions
  localparam int TEST_EN_BIT = 7;
  localparam int DIG_LB_BIT = 6;
  localparam int ANA_LB_BIT = 5;
  localparam int REM_LB_BIT = 4;

  // Receive gain codes
  localparam logic [1:0] GAIN_CODE_6DB = 2'h0;
  localparam logic [1:0] GAIN_CODE_9DB = 2'h1;
  localparam logic [1:0] GAIN_CODE_12DB = 2'h2;
  localparam logic [1:0] GAIN_CODE_0DB = 2'h3;

  // Receive gain in dB for each code, and the boost amount
  localparam logic [5:0] GAIN_6DB = 6'h06;
  localparam logic [5:0] GAIN_9DB = 6'h09;
  localparam logic [5:0] GAIN_12DB = 6'h0c;
  localparam logic [5:0] GAIN_0DB = 6'h00;
  localparam logic [5:0] BOOST_DB = 6'h14;

  // Register read and write request from the serial control frame logic
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afecr_req_t;

  // Decoded analog and datapath controls
  typedef struct packed {
    logic       fe_run;
    logic       clk_run;
    logic       tx1_drive;
    logic       tx2_drive;
    logic       tx_bias_only;
    logic [5:0] rx_gain_db;
    logic [1:0] tx_boost;
    logic       test_mode;
    logic       dig_loop;
    logic       ana_loop;
    logic       rem_loop;
  } afecr_ctl_t;

endpackage

// ---- afecr_gain_dec.sv ----
// Receive gain decoder for the front-end control register
`timescale 1ns/1ps
module afecr_gain_dec (
  input wire logic [1:0] i_gain_sel,
  input wire logic i_boost,
  output logic [5:0] o_gain_db
);

  // Map the two-bit code to a base gain
  function automatic logic [5:0] base_gain(input logic [1:0] code);
    case (code)
      afecr_pkg::GAIN_CODE_6DB: base_gain = afecr_pkg::GAIN_6DB;
      afecr_pkg::GAIN_CODE_9DB: base_gain = afecr_pkg::GAIN_9DB;
      afecr_pkg::GAIN_CODE_12DB: base_gain = afecr_pkg::GAIN_12DB;
      afecr_pkg::GAIN_CODE_0DB: base_gain = afecr_pkg::GAIN_0DB;
      default: base_gain = afecr_pkg::GAIN_0DB;
    endcase
  endfunction

  // Base gain plus optional boost
  always_comb begin
    o_gain_db = base_gain(i_gain_sel); // R4
    if (i_boost) begin
      o_gain_db = 6'(base_gain(i_gain_sel) + afecr_pkg::BOOST_DB); // R5
    end
  end

endmodule

// ---- afecr_regs.sv ----
// Front-end control and test register bank with decoded controls
//
// Behaviour
// R1 - Front-end enable runs filters, else clocks stop
// R2 - Driver select picks secondary pair when set
// R3 - Transmit disable tri-states both pairs with bias
// R4 - Gain codes give 6, 9, 12, 0 dB
// R5 - Receive boost adds 20 dB gain
// R6 - Test-mode enable turns on test modes
// R7 - Digital loopback feeds transmit filter to receive
// R8 - Analog loopback ties transmit output to receiver
// R9 - Remote loopback ties receiver output to transmitter
`timescale 1ns/1ps
module afecr_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire afecr_pkg::afecr_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output afecr_pkg::afecr_ctl_t o_ctl
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  // Control register contents
  logic [7:0] fe_ctrl_reg;
  // Test and loopback register contents
  logic [7:0] test_lb_reg;
  // Read data and valid
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  // Decoded control outputs
  afecr_pkg::afecr_ctl_t ctl_reg;
  afecr_pkg::afecr_ctl_t ctl_next;
  // Gain from the decoder
  logic [5:0] gain_db;

  // Address match helper, used for both write and read decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
    addr_hit = (a == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Host writes

  // Control register write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      fe_ctrl_reg <= afecr_pkg::FE_CTRL_RST;
    end else if (i_req.wr && addr_hit(i_req.addr,
                                      afecr_pkg::FE_CTRL_ADDR)) begin
      fe_ctrl_reg <= i_req.wdata;
    end
  end

  // Test register write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      test_lb_reg <= afecr_pkg::TEST_LB_RST;
    end else if (i_req.wr && addr_hit(i_req.addr,
                                      afecr_pkg::TEST_LB_ADDR)) begin
      test_lb_reg <= i_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host reads

  // One-cycle read answer, unmapped addresses read zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= i_req.rd;
      if (!i_req.rd) begin
        rdata_reg <= 8'h00;
      end else if (addr_hit(i_req.addr, afecr_pkg::FE_CTRL_ADDR)) begin
        rdata_reg <= fe_ctrl_reg;
      end else if (addr_hit(i_req.addr, afecr_pkg::TEST_LB_ADDR)) begin
        rdata_reg <= test_lb_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control decode

  // Receive gain decode
  afecr_gain_dec u_gain_dec (
    .i_gain_sel(fe_ctrl_reg[afecr_pkg::RX_GAIN_HI_BIT:
                            afecr_pkg::RX_GAIN_LO_BIT]),
    .i_boost(fe_ctrl_reg[afecr_pkg::RX_BOOST_BIT]),
    .o_gain_db(gain_db)
  );

  // Next control values from register contents
  always_comb begin
    ctl_next = '0;
    // Front end and clocks run only when enabled
    ctl_next.fe_run = fe_ctrl_reg[afecr_pkg::FE_EN_BIT]; // R1
    ctl_next.clk_run = fe_ctrl_reg[afecr_pkg::FE_EN_BIT]; // R1
    // Drivers only when not disabled; selection picks the pair
    ctl_next.tx2_drive = !fe_ctrl_reg[afecr_pkg::TX_DIS_BIT] &&
                         fe_ctrl_reg[afecr_pkg::DRV2_SEL_BIT]; // R2
    ctl_next.tx1_drive = !fe_ctrl_reg[afecr_pkg::TX_DIS_BIT] &&
                         !fe_ctrl_reg[afecr_pkg::DRV2_SEL_BIT]; // R2
    // Both pairs high impedance with bias
    ctl_next.tx_bias_only = fe_ctrl_reg[afecr_pkg::TX_DIS_BIT]; // R3
    ctl_next.rx_gain_db = gain_db; // R4
    ctl_next.tx_boost = {fe_ctrl_reg[afecr_pkg::TX_BOOST1_BIT],
                         fe_ctrl_reg[afecr_pkg::TX_BOOST0_BIT]};
    ctl_next.test_mode = test_lb_reg[afecr_pkg::TEST_EN_BIT]; // R6
    ctl_next.dig_loop = test_lb_reg[afecr_pkg::DIG_LB_BIT]; // R7
    ctl_next.ana_loop = test_lb_reg[afecr_pkg::ANA_LB_BIT]; // R8
    ctl_next.rem_loop = test_lb_reg[afecr_pkg::REM_LB_BIT]; // R9
  end

  // Registered control outputs
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_ctl = ctl_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  // Front end and clocks follow the enable bit one cycle later
  AST_FE_RUN: assert property ( // R1
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    ##1 o_ctl.fe_run == $past(fe_ctrl_reg[7]) &&
        o_ctl.clk_run == $past(fe_ctrl_reg[7]))
    else $error("Front-end run does not follow enable bit");

  // Cleared enable stops front end and clocks
  AST_FE_STOP: assert property ( // R1
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !fe_ctrl_reg[afecr_pkg::FE_EN_BIT] |=> !o_ctl.fe_run && !o_ctl.clk_run)
    else $error("Front end still running while disabled");

  // Secondary pair drives when selected and enabled
  AST_DRV_SEL: assert property ( // R2
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[3:3] == 1'b0 && fe_ctrl_reg[6]) |=>
      o_ctl.tx2_drive && !o_ctl.tx1_drive)
    else $error("Secondary pair not selected");

  // Primary pair drives when not selected and enabled
  AST_TX1_SEL: assert property ( // R2
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (!fe_ctrl_reg[afecr_pkg::TX_DIS_BIT] &&
     !fe_ctrl_reg[afecr_pkg::DRV2_SEL_BIT]) |=>
      o_ctl.tx1_drive && !o_ctl.tx2_drive)
    else $error("Primary pair not selected");

  // Disable leaves both pairs undriven with bias
  AST_TX_DIS: assert property ( // R3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    fe_ctrl_reg[3] |=> !o_ctl.tx1_drive && !o_ctl.tx2_drive &&
                       o_ctl.tx_bias_only)
    else $error("Transmit pairs driven while disabled");

  // Bias only while disabled
  AST_TX_EN: assert property ( // R3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !fe_ctrl_reg[afecr_pkg::TX_DIS_BIT] |=> !o_ctl.tx_bias_only)
    else $error("Bias applied while transmit enabled");

  // Code 00 without boost
  AST_GAIN_6: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h0) |=> o_ctl.rx_gain_db == 6'h06)
    else $error("Gain code 00 not 6 dB");

  // Code 01 without boost
  AST_GAIN_9: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h2) |=> o_ctl.rx_gain_db == 6'h09)
    else $error("Gain code 01 not 9 dB");

  // Code 10 without boost
  AST_GAIN_12: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h4) |=> o_ctl.rx_gain_db == 6'h0c)
    else $error("Gain code 10 not 12 dB");

  // Code 11 without boost
  AST_GAIN_0: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h6) |=> o_ctl.rx_gain_db == 6'h00)
    else $error("Gain code 11 not 0 dB");

  // Boost over code 01
  AST_BOOST: assert property ( // R5
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h3) |=> o_ctl.rx_gain_db == 6'h1d)
    else $error("Boost not 20 dB over 9 dB");

  // Boost over code 00
  AST_BOOST_6: assert property ( // R5
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h1) |=> o_ctl.rx_gain_db == 6'h1a)
    else $error("Boost not 20 dB over 6 dB");

  // Boost over code 10
  AST_BOOST_12: assert property ( // R5
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h5) |=> o_ctl.rx_gain_db == 6'h20)
    else $error("Boost not 20 dB over 12 dB");

  // Boost over code 11
  AST_BOOST_0: assert property ( // R5
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (fe_ctrl_reg[2:0] == 3'h7) |=> o_ctl.rx_gain_db == 6'h14)
    else $error("Boost not 20 dB over 0 dB");

  // Test mode follows a test register write two cycles later
  AST_TEST_MODE: assert property ( // R6
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.wr && i_req.addr == 8'h01) |-> ##2
      o_ctl.test_mode == $past(i_req.wdata[7], 2))
    else $error("Test mode does not follow write");

  // Cleared test enable keeps normal operation
  AST_TEST_OFF: assert property ( // R6
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !test_lb_reg[afecr_pkg::TEST_EN_BIT] |=> !o_ctl.test_mode)
    else $error("Test mode set while bit clear");

  // Digital loopback follows a test register write
  AST_DIG_LOOP: assert property ( // R7
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.wr && i_req.addr == 8'h01) |-> ##2
      o_ctl.dig_loop == $past(i_req.wdata[6], 2))
    else $error("Digital loopback does not follow write");

  // Cleared digital loopback keeps normal path
  AST_DIG_OFF: assert property ( // R7
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !test_lb_reg[afecr_pkg::DIG_LB_BIT] |=> !o_ctl.dig_loop)
    else $error("Digital loopback set while bit clear");

  // Analog loopback applied after its bit rises
  AST_ANA_LOOP: assert property ( // R8
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(test_lb_reg[5]) |=> o_ctl.ana_loop)
    else $error("Analog loopback not applied");

  // Cleared analog loopback keeps normal path
  AST_ANA_OFF: assert property ( // R8
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !test_lb_reg[afecr_pkg::ANA_LB_BIT] |=> !o_ctl.ana_loop)
    else $error("Analog loopback set while bit clear");

  // Remote loopback released after its bit falls
  AST_REM_LOOP: assert property ( // R9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    $fell(test_lb_reg[4]) |=> !o_ctl.rem_loop)
    else $error("Remote loopback not released");

  // Remote loopback held while its bit is set
  AST_REM_SET: assert property ( // R9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    test_lb_reg[afecr_pkg::REM_LB_BIT] |=> o_ctl.rem_loop)
    else $error("Remote loopback not applied");

  // Control register read answers the stored value
  AST_READ_BACK: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == 8'h00) |=> o_rvalid &&
      o_rdata == $past(fe_ctrl_reg))
    else $error("Control register read back wrong");

  // Test register read answers the stored value
  AST_TEST_READ: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == 8'h01) |=> o_rvalid &&
      o_rdata == $past(test_lb_reg))
    else $error("Test register read back wrong");

  // Unmapped reads answer zero
  AST_UNMAPPED_RD: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr > 8'h01) |=> o_rvalid && o_rdata == 8'h00)
    else $error("Unmapped read not zero");

  // Unmapped writes leave both registers untouched
  AST_UNMAPPED_WR: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.wr && i_req.addr > 8'h01) |=>
      $stable(fe_ctrl_reg) && $stable(test_lb_reg))
    else $error("Unmapped write changed a register");

  // No read request, no answer and zero data
  AST_RVALID_IDLE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_req.rd |=> !o_rvalid && o_rdata == 8'h00)
    else $error("Read answer without request");

  // Reset clears every decoded control and the read answer
  AST_RESET_CTL: assert property (
    @(posedge i_ref_clk)
    !i_rst_b |=> o_ctl == '0 && !o_rvalid && o_rdata == 8'h00)
    else $error("Outputs not cleared by reset");

  // Main scenarios
  COV_TX2: cover property (@(posedge i_ref_clk) o_ctl.tx2_drive);
  COV_DIS: cover property (@(posedge i_ref_clk) o_ctl.tx_bias_only);
  COV_BOOST: cover property (@(posedge i_ref_clk)
    o_ctl.rx_gain_db == 6'h20);
  COV_LOOP: cover property (@(posedge i_ref_clk)
    o_ctl.dig_loop && o_ctl.test_mode);

endmodule

// ---- test_afe_control_test_registers.sv ----
// Self-checking testbench for the front-end control and test registers
`timescale 1ns/1ps
module test_afe_control_test_registers;
  ////////////////////////////////////////////////////////////////////////
  // Signals and stimulus tables
  logic i_ref_clk; // Reference clock
  logic i_rst_b; // Synchronous reset, active low
  afecr_pkg::afecr_req_t req; // Access request into the bank
  logic [7:0] rdata; // Read data
  logic rvalid; // Read answer strobe
  afecr_pkg::afecr_ctl_t ctl; // Decoded controls
  int fails; // Mismatch count
  int samples_checked; // Comparison count
  // Control values covering all gain codes, boost, drive and disable
  logic [7:0] cv [8] = '{8'h80, 8'hc3, 8'h85, 8'h47,
                         8'hb4, 8'h0e, 8'hca, 8'h01};
  // Test values: a mix, each path alone, then back to normal
  logic [7:0] tv [6] = '{8'hf5, 8'h80, 8'h40, 8'h20, 8'h10, 8'h00};

  afecr_regs u_afecr_regs (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_req(req),
    .o_rdata(rdata),
    .o_rvalid(rvalid),
    .o_ctl(ctl)
  );

  // Free-running 250 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write, request held across its taking edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk);
    #1 req = '0;
  endtask

  // One-cycle read, answer looked at in its only valid cycle
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_ref_clk);
    #1 req = '0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask

  // Expected decode of a control register value
  task ctl_chk(input logic [7:0] d);
    logic [7:0] g;
    g = (d[2:1] == 2'h0) ? 8'h06 : (d[2:1] == 2'h1) ? 8'h09 :
        (d[2:1] == 2'h2) ? 8'h0c : 8'h00;
    if (d[0]) g = g + 8'h14;
    chk({7'h00, ctl.fe_run}, {7'h00, d[7]});
    chk({7'h00, ctl.clk_run}, {7'h00, d[7]});
    chk({7'h00, ctl.tx2_drive}, {7'h00, d[6] & ~d[3]});
    chk({7'h00, ctl.tx1_drive}, {7'h00, ~d[6] & ~d[3]});
    chk({7'h00, ctl.tx_bias_only}, {7'h00, d[3]});
    chk({2'h0, ctl.rx_gain_db}, g);
    chk({6'h00, ctl.tx_boost}, {6'h00, d[5:4]});
  endtask

  // Expected decode of a test register value
  task tst_chk(input logic [7:0] d);
    chk({7'h00, ctl.test_mode}, {7'h00, d[7]});
    chk({7'h00, ctl.dig_loop}, {7'h00, d[6]});
    chk({7'h00, ctl.ana_loop}, {7'h00, d[5]});
    chk({7'h00, ctl.rem_loop}, {7'h00, d[4]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task test_reset;
    i_rst_b = 1'b0;
    repeat (10) @(posedge i_ref_clk);
    #1 i_rst_b = 1'b1;
    @(posedge i_ref_clk);
    #1 ctl_chk(8'h08);
    tst_chk(8'h00);
    rd(8'h00, 8'h08);
    rd(8'h01, 8'h00);
    $display("test_reset done");
  endtask

  task test_ctrl;
    foreach (cv[i]) begin
      wr(8'h00, cv[i]);
      @(posedge i_ref_clk);
      #1 ctl_chk(cv[i]);
      rd(8'h00, cv[i]);
    end
    $display("test_ctrl done");
  endtask

  task test_test;
    foreach (tv[i]) begin
      wr(8'h01, tv[i]);
      @(posedge i_ref_clk);
      #1 tst_chk(tv[i]);
      rd(8'h01, tv[i]);
    end
    // Unmapped place: write ignored, read answers zero
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h00);
    rd(8'h00, cv[7]);
    rd(8'h01, tv[5]);
    $display("test_test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end

  initial begin
    fails = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    req = '0;
    test_reset();
    test_ctrl();
    test_test();
    test_reset();
    tally_and_finish();
  end
endmodule
